//--- rtl/pli_led_mux.sv
// Per-port LED indicator mux for a nine-port switch
// Function
// - Mode 0 first LED shows 100 speed.
// - Mode 1 first LED: link, speed-rate activity blink.
// - Mode 2 first LED shows collision.
// - Mode 3 first LED shows 100 speed.
// - Mode 1 second LED shows full duplex.
// - Mode 1 third LED lit while transmitting.
// - Mode 2 third LED: 10 Mb activity only.
// - Mode 3 third LED: duplex, collision blink.
// - Mode 0 fourth LED: link solid, traffic blinks.
// - Mode 1 fourth LED lit while receiving.
// - Mode 2 fourth LED: 100 Mb activity only.
// - Mode 3 fourth LED same as mode 0.
// - Strap sampled on first edge after reset, outputs driven after.
// - Codes 0000, 0001 decode modes 0, 1.
// - Codes 0010, 0011 modes 2, 3; others reserved.
`include "pli_regs.svh"
module pli_led_mux #(
  parameter int NPORT = `PLI_NPORT,
  parameter int CNT_W = `PLI_CNT_W,
  parameter int SLOW_BIT = `PLI_SLOW_BIT,
  parameter int FAST_BIT = `PLI_FAST_BIT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Mode strap
  input wire logic [`PLI_MODE_W-1:0] led_mode_strap_i,
  // Per-port status
  input wire logic [NPORT-1:0] link_up_i,
  input wire logic [NPORT-1:0] speed_100_i,
  input wire logic [NPORT-1:0] full_duplex_i,
  input wire logic [NPORT-1:0] collision_i,
  input wire logic [NPORT-1:0] tx_active_i,
  input wire logic [NPORT-1:0] rx_active_i,
  // Active-low indicators
  output logic [NPORT-1:0] port_indicator_0_o,
  output logic [NPORT-1:0] port_indicator_1_o,
  output logic [NPORT-1:0] port_indicator_2_o,
  output logic [NPORT-1:0] port_indicator_3_o
);
  typedef struct packed {
    logic cap;
    logic cap_seen;
    logic [`PLI_MODE_W-1:0] code;
    logic [NPORT-1:0] ind0;
    logic [NPORT-1:0] ind1;
    logic [NPORT-1:0] ind2;
    logic [NPORT-1:0] ind3;
  } pli_mux_st_t;

  pli_mux_st_t st_r;
  pli_mux_st_t st_nxt;
  pli_pkg::pli_led_mode_t mode;
  pli_blink_if blink_if ();

  initial begin
    if (NPORT < 1)
      $error("pli_led_mux: NPORT must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////
  // Blink phase source shared by all ports
  pli_blink #(
    .CNT_W(CNT_W),
    .SLOW_BIT(SLOW_BIT),
    .FAST_BIT(FAST_BIT)
  ) u_blink (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .blink(blink_if)
  );

  ////////////////////////////////////////////////////////////////////////
  // Strap code to LED mode
  function automatic pli_pkg::pli_led_mode_t decode_mode(
    input logic [`PLI_MODE_W-1:0] code);
    pli_pkg::pli_led_mode_t m;
    case (code)
      `PLI_CODE_SPEED: m = pli_pkg::PLI_MODE_SPEED;
      `PLI_CODE_LINKACT: m = pli_pkg::PLI_MODE_LINKACT;
      `PLI_CODE_COLL: m = pli_pkg::PLI_MODE_COLL;
      `PLI_CODE_DUPLEX: m = pli_pkg::PLI_MODE_DUPLEX;
      default: m = pli_pkg::PLI_MODE_RSVD;
    endcase
    return m;
  endfunction : decode_mode

  // Link plus activity: solid when idle, blinks with traffic
  function automatic logic link_act(input logic link, input logic act,
                                    input logic phase);
    return link & (~act | phase);
  endfunction : link_act

  assign mode = decode_mode(st_r.code);

  ////////////////////////////////////////////////////////////////////////
  // Next state: capture strap once, then map status per mode
  always_comb begin
    logic [NPORT-1:0] lit0;
    logic [NPORT-1:0] lit1;
    logic [NPORT-1:0] lit2;
    logic [NPORT-1:0] lit3;
    logic act;
    logic rate;
    lit0 = '0;
    lit1 = '0;
    lit2 = '0;
    lit3 = '0;
    act = 1'b0;
    rate = 1'b0;
    st_nxt = st_r;
    // Capture flag one cycle late, gates the checks below
    st_nxt.cap_seen = st_r.cap;
    // strap caught on first edge after release
    if (!st_r.cap) begin
      st_nxt.cap = 1'b1;
      st_nxt.code = led_mode_strap_i;
    end
    for (int i = 0; i < NPORT; i++) begin
      act = tx_active_i[i] | rx_active_i[i];
      rate = speed_100_i[i] ? blink_if.fast : blink_if.slow;
      case (mode)
        pli_pkg::PLI_MODE_SPEED: begin
          lit0[i] = speed_100_i[i];
          lit1[i] = full_duplex_i[i];
          lit2[i] = collision_i[i];
          lit3[i] = link_act(link_up_i[i], act, blink_if.slow);
        end
        pli_pkg::PLI_MODE_LINKACT: begin
          lit0[i] = link_act(link_up_i[i], act, rate);
          lit1[i] = full_duplex_i[i];
          lit2[i] = tx_active_i[i];
          lit3[i] = rx_active_i[i];
        end
        pli_pkg::PLI_MODE_COLL: begin
          lit0[i] = collision_i[i];
          lit1[i] = full_duplex_i[i];
          lit2[i] = ~speed_100_i[i] & link_act(link_up_i[i], act, blink_if.slow);
          lit3[i] = speed_100_i[i] & link_act(link_up_i[i], act, blink_if.fast);
        end
        pli_pkg::PLI_MODE_DUPLEX: begin
          lit0[i] = speed_100_i[i];
          lit1[i] = full_duplex_i[i];
          lit2[i] = full_duplex_i[i] | (collision_i[i] & blink_if.fast);
          lit3[i] = link_act(link_up_i[i], act, blink_if.slow);
        end
        default: begin
          // Factory codes: keep every LED dark
          lit0[i] = 1'b0;
        end
      endcase
    end
    st_nxt.ind0 = st_r.cap ? ~lit0 : {NPORT{`PLI_DARK}};
    st_nxt.ind1 = st_r.cap ? ~lit1 : {NPORT{`PLI_DARK}};
    st_nxt.ind2 = st_r.cap ? ~lit2 : {NPORT{`PLI_DARK}};
    st_nxt.ind3 = st_r.cap ? ~lit3 : {NPORT{`PLI_DARK}};
  end

  // State register; LEDs dark in reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r.cap <= 1'b0;
      st_r.cap_seen <= 1'b0;
      st_r.code <= `PLI_CODE_SPEED;
      st_r.ind0 <= {NPORT{`PLI_DARK}};
      st_r.ind1 <= {NPORT{`PLI_DARK}};
      st_r.ind2 <= {NPORT{`PLI_DARK}};
      st_r.ind3 <= {NPORT{`PLI_DARK}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Indicators straight from flops
  assign port_indicator_0_o = st_r.ind0;
  assign port_indicator_1_o = st_r.ind1;
  assign port_indicator_2_o = st_r.ind2;
  assign port_indicator_3_o = st_r.ind3;

  ////////////////////////////////////////////////////////////////////////
  // Checks; run means mode was valid in the previous cycle too
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic run;
  assign run = st_r.cap & st_r.cap_seen;

  property p_m0_speed;
    run && mode == pli_pkg::PLI_MODE_SPEED |->
      port_indicator_0_o == ~$past(speed_100_i);
  endproperty
  a_m0_speed: assert property (p_m0_speed) else $error("mode0 led0 speed");

  property p_m1_linkdown;
    run && mode == pli_pkg::PLI_MODE_LINKACT |->
      (port_indicator_0_o | $past(link_up_i)) == {NPORT{1'b1}};
  endproperty
  a_m1_linkdown: assert property (p_m1_linkdown) else $error("mode1 led0 lit unlinked");

  property p_m2_coll;
    run && mode == pli_pkg::PLI_MODE_COLL |-> port_indicator_0_o == ~$past(collision_i);
  endproperty
  a_m2_coll: assert property (p_m2_coll) else $error("mode2 led0 collision");

  property p_m1_duplex;
    run && mode == pli_pkg::PLI_MODE_LINKACT |->
      port_indicator_1_o == ~$past(full_duplex_i);
  endproperty
  a_m1_duplex: assert property (p_m1_duplex) else $error("mode1 led1 duplex");

  property p_m1_tx;
    run && mode == pli_pkg::PLI_MODE_LINKACT |-> port_indicator_2_o == ~$past(tx_active_i);
  endproperty
  a_m1_tx: assert property (p_m1_tx) else $error("mode1 led2 transmit");

  property p_m1_rx;
    run && mode == pli_pkg::PLI_MODE_LINKACT |-> port_indicator_3_o == ~$past(rx_active_i);
  endproperty
  a_m1_rx: assert property (p_m1_rx) else $error("mode1 led3 receive");

  property p_m3_fdx;
    run && mode == pli_pkg::PLI_MODE_DUPLEX |->
      (port_indicator_2_o & $past(full_duplex_i)) == {NPORT{1'b0}};
  endproperty
  a_m3_fdx: assert property (p_m3_fdx) else $error("mode3 led2 full duplex dark");

  property p_m0_idle;
    run && mode == pli_pkg::PLI_MODE_SPEED |->
      ((port_indicator_3_o ^ ~$past(link_up_i)) &
       ~($past(link_up_i) & $past(tx_active_i | rx_active_i))) == {NPORT{1'b0}};
  endproperty
  a_m0_idle: assert property (p_m0_idle) else $error("mode0 led3 idle link");

  property p_reset_dark;
    !st_r.cap |=> port_indicator_0_o == {NPORT{1'b1}} && port_indicator_3_o == {NPORT{1'b1}};
  endproperty
  a_reset_dark: assert property (p_reset_dark) else $error("LEDs lit before strap");

  property p_code_held;
    st_r.cap |=> $stable(st_r.code) [*3];
  endproperty
  a_code_held: assert property (p_code_held) else $error("mode code changed");

  property p_rsvd_dark;
    run && mode == pli_pkg::PLI_MODE_RSVD |-> port_indicator_2_o == {NPORT{1'b1}};
  endproperty
  a_rsvd_dark: assert property (p_rsvd_dark) else $error("reserved code lit LED");

  c_mode0: cover property (run && mode == pli_pkg::PLI_MODE_SPEED);
  c_mode1: cover property (run && mode == pli_pkg::PLI_MODE_LINKACT);
  c_mode2: cover property (run && mode == pli_pkg::PLI_MODE_COLL);
  c_mode3: cover property (run && mode == pli_pkg::PLI_MODE_DUPLEX);
endmodule : pli_led_mux

//--- rtl/pli_regs.svh
// Constants for the port LED indicator mux
`ifndef PLI_REGS_SVH
`define PLI_REGS_SVH
`define PLI_NPORT 9
`define PLI_MODE_W 4
`define PLI_CODE_SPEED 4'h0
`define PLI_CODE_LINKACT 4'h1
`define PLI_CODE_COLL 4'h2
`define PLI_CODE_DUPLEX 4'h3
`define PLI_SLOW_BIT 23
`define PLI_FAST_BIT 21
`define PLI_CNT_W 24
`define PLI_DARK 1'b1
`endif

//--- rtl/pli_pkg.sv
// Types shared by the port LED indicator mux
package pli_pkg;
  typedef enum {
    PLI_MODE_SPEED,
    PLI_MODE_LINKACT,
    PLI_MODE_COLL,
    PLI_MODE_DUPLEX,
    PLI_MODE_RSVD
  } pli_led_mode_t;
endpackage : pli_pkg

//--- rtl/pli_blink_if.sv
// Blink phase signals from the blink generator to the mux
interface pli_blink_if;
  logic slow;
  logic fast;
  modport gen (output slow, output fast);
  modport use_ (input slow, input fast);
endinterface : pli_blink_if

//--- rtl/pli_blink.sv
// Free-running blink phase generator
`include "pli_regs.svh"
module pli_blink #(
  parameter int CNT_W = `PLI_CNT_W,
  parameter int SLOW_BIT = `PLI_SLOW_BIT,
  parameter int FAST_BIT = `PLI_FAST_BIT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Blink phases
  pli_blink_if.gen blink
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } pli_blink_st_t;

  pli_blink_st_t st_r;
  pli_blink_st_t st_nxt;

  // Fast phase must toggle faster than slow phase
  initial begin
    if (!(FAST_BIT < SLOW_BIT && SLOW_BIT < CNT_W && FAST_BIT >= 0))
      $error("pli_blink: bad blink bit positions");
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.cnt = st_r.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Phases straight from counter flops
  assign blink.slow = st_r.cnt[SLOW_BIT];
  assign blink.fast = st_r.cnt[FAST_BIT];
endmodule : pli_blink

//--- verification/pli_led_model.sv
// Model of the external indicator LEDs of every port
module pli_led_model #(
  parameter int NPORT = 9
) (
  // Indicator pins
  input wire logic [NPORT-1:0] ind0_i,
  input wire logic [NPORT-1:0] ind1_i,
  input wire logic [NPORT-1:0] ind2_i,
  input wire logic [NPORT-1:0] ind3_i,
  // Lamp state, one nibble per port
  output logic [4*NPORT-1:0] lit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      lit_o[4*p +: 4] = ~{ind3_i[p], ind2_i[p], ind1_i[p], ind0_i[p]};
    end
  end
endmodule : pli_led_model

//--- verification/tb.sv
// Self-checking bench for the port LED indicator mux
`include "pli_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NP = `PLI_NPORT;
  localparam int W = 4 * NP;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [`PLI_MODE_W-1:0] strap = 4'h0;
  logic [NP-1:0] link = '0, spd = '0, fdx = '0, col = '0, tx = '0, rx = '0;
  logic [NP-1:0] ind0, ind1, ind2, ind3;
  logic [W-1:0] lit;
  logic [W-1:0] c_m;
  logic [W-1:0] q_exp[$];
  logic [W-1:0] q_care[$];
  logic [31:0] seed = 32'h4FCA;
  int fails = 0;
  int checks_done = 0;

  ////////////////////////////////////////////////////////////////
  // Clock; short blink counter keeps blink periods inside a run
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  pli_led_mux #(.NPORT(NP), .CNT_W(6), .SLOW_BIT(4), .FAST_BIT(2)) pli_led_mux_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .led_mode_strap_i(strap),
    .link_up_i(link), .speed_100_i(spd), .full_duplex_i(fdx),
    .collision_i(col), .tx_active_i(tx), .rx_active_i(rx),
    .port_indicator_0_o(ind0), .port_indicator_1_o(ind1),
    .port_indicator_2_o(ind2), .port_indicator_3_o(ind3)
  );

  pli_led_model #(.NPORT(NP)) pli_led_model_inst (
    .ind0_i(ind0), .ind1_i(ind1), .ind2_i(ind2), .ind3_i(ind3), .lit_o(lit)
  );

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift

  // Returns {care, lit}; blinking lamps are left out of care
  function automatic logic [7:0] port_exp(input logic [3:0] m, input logic l, input logic s,
                                          input logic f, input logic c, input logic a,
                                          input logic t, input logic r);
    logic [3:0] lt;
    logic [3:0] ca;
    lt = 4'h0;
    ca = 4'hF;
    case (m)
      4'h0, 4'h3: begin
        lt = {l, (m == 4'h3) ? f : c, f, s};
        ca[3] = !(l && a);
        if (m == 4'h3) ca[2] = f | !c;
      end
      4'h1: begin
        lt = {r, t, f, l};
        ca[0] = !(l && a);
      end
      4'h2: begin
        lt = {l & s, l & !s, f, c};
        ca[3] = !(l && s && a);
        ca[2] = !(l && !s && a);
      end
      default: ca = 4'hF;
    endcase
    return {ca, lt};
  endfunction : port_exp

  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("Checks done %0d, failures %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////
  // Reset with a strap code, then random status for n cycles
  task automatic run(input logic [3:0] code, input int n);
    logic [31:0] a;
    logic [31:0] b;
    logic [W-1:0] e;
    logic [W-1:0] c;
    logic [7:0] pe;
    @(negedge clk_i);
    nrst_i = 1'b0;
    strap = code;
    q_exp.delete();
    q_care.delete();
    repeat (6) @(negedge clk_i);
    nrst_i = 1'b1;
    // Capture edge still dark
    q_exp.push_back('0);
    q_care.push_back('1);
    // Inputs before the capture edge never show, so start after it
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      // Strap noise after capture must be ignored
      strap = 4'(xorshift() >> 7);
      a = xorshift();
      b = xorshift();
      {link, spd, fdx} = a[26:0];
      {col, tx, rx} = b[26:0];
      for (int p = 0; p < NP; p++) begin
        pe = port_exp(code, link[p], spd[p], fdx[p], col[p], tx[p] | rx[p], tx[p], rx[p]);
        e[4*p +: 4] = pe[3:0];
        c[4*p +: 4] = pe[7:4];
      end
      q_exp.push_back(e);
      q_care.push_back(c);
    end
  endtask : run

  // Steady traffic on every port; lamp must both light and go dark
  task automatic blink(input logic [3:0] code, input int led, input logic s, input logic fr);
    int on;
    int off;
    int tr;
    logic prev;
    run(code, 1);
    @(negedge clk_i);
    link = '1;
    spd = {NP{s}};
    fdx = '0;
    col = '1;
    tx = '1;
    rx = '0;
    on = 0;
    off = 0;
    tr = 0;
    prev = lit[led];
    repeat (80) begin
      @(negedge clk_i);
      if (lit[led] !== prev) tr++;
      prev = lit[led];
      if (lit[led] === 1'b1) on++;
      else off++;
    end
    check(W'(on > 0 && off > 0), W'(1));
    // Fast phase toggles about every 4 cycles, slow about every 16
    check(W'(tr > 10), W'(fr));
  endtask : blink

  ////////////////////////////////////////////////////////////////
  // Output watcher: one note per clock while notes are pending
  always @(posedge clk_i) begin
    #1;
    if (!nrst_i) begin
      check(lit, '0);
    end else if (q_exp.size() > 0) begin
      c_m = q_care.pop_front();
      check(lit & c_m, q_exp.pop_front() & c_m);
    end
  end

  initial begin
    for (int m = 0; m < 16; m++) begin
      run(m[3:0], 60);
    end
    blink(4'h0, 3, 1'b0, 1'b0);
    blink(4'h1, 0, 1'b1, 1'b1);
    blink(4'h1, 0, 1'b0, 1'b0);
    blink(4'h2, 2, 1'b0, 1'b0);
    blink(4'h2, 3, 1'b1, 1'b1);
    blink(4'h3, 2, 1'b0, 1'b1);
    repeat (3) @(negedge clk_i);
    summarize();
  end
endmodule : tb
